// ---- core/evt_flags_pkg.sv ----
// Purpose: shared constants and carrier types for the event status flags
// Assumes: one system clock at 100 MHz, asynchronous active-low reset
// Notes: the register is reached on a plain word port, no public bus
package evt_flags_pkg;

  // ****************************************************************
  // register layout
  // ****************************************************************
  localparam logic [15:0] EVT_STATUS_ADDR = 16'h0400;
  localparam logic [31:0] EVT_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] EVT_IMPL_MASK = 32'h0FFF_FFC0;
  localparam int unsigned BIT_PULSE1 = 6;
  localparam int unsigned BIT_PULSE2 = 7;
  localparam int unsigned BIT_RMS_ONE = 8;
  localparam int unsigned BIT_POWER_FACTOR_READY_FLAG = 9;
  localparam int unsigned BIT_ISUM = 10;
  localparam int unsigned BIT_ACT_NL = 11;
  localparam int unsigned BIT_APP_NL = 12;
  localparam int unsigned BIT_CONFIG_CHECKSUM_CHANGED_FLAG = 13;
  localparam int unsigned BIT_RST_DONE = 14;
  localparam int unsigned BIT_ORDER = 15;
  localparam int unsigned BIT_TIMEOUT_A = 16;
  localparam int unsigned BIT_VZX_A = 19;
  localparam int unsigned BIT_VZX_COMB = 22;
  localparam int unsigned BIT_IZX_A = 23;
  localparam int unsigned BIT_AUXILIARY_CHANNEL_0 = 26;
  localparam int unsigned BIT_AUXILIARY_CHANNEL_1 = 27;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam longint unsigned PF_PERIOD_S = 1;
  localparam longint unsigned PF_PERIOD_CYCLES =
    (PF_PERIOD_S * 64'd1_000_000_000) / CLK_PERIOD_NS;
  localparam int unsigned RST_DONE_CYCLES = 16;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [1:0] aux_zx;
    logic [2:0] cur_zx;
    logic comb_zx;
    logic [2:0] volt_zx;
    logic [2:0] zx_timeout;
    logic rms_one_upd;
  } zx_events_t;

  typedef struct packed {
    logic [2:0] app_noload;
    logic [2:0] act_noload;
    logic isum_over;
    logic [15:0] crc_value;
  } levels_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// ---- core/evt_edge_watch.sv ----
// Purpose: flags a change of a level vector and a high-to-low edge
// Assumes: inputs synchronous to i_clk
// Notes: first sample after reset is taken as the baseline, no event
`timescale 1ns/10ps
module evt_edge_watch #(
  parameter int unsigned W = 8
) (
  input wire logic i_clk, // system clock
  input wire logic i_resetn, // async reset, active low
  input wire logic [W-1:0] i_level, // watched levels
  output logic o_changed, // any bit changed, pulse
  output logic [W-1:0] o_fell // per-bit high-to-low, pulse
);
  logic [W-1:0] prev_q;
  logic armed_q;

  assign o_changed = armed_q && (prev_q != i_level);
  assign o_fell = armed_q ? (prev_q & ~i_level) : '0;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_q <= '0;
      armed_q <= 1'b0;
    end else begin
      prev_q <= i_level;
      armed_q <= 1'b1;
    end
  end
endmodule // evt_edge_watch

// ---- core/metrology_event_status_flags.sv ----
// Purpose: sticky event status word, bits 27..6, write one to clear
// Assumes: datapath delivers one-cycle event pulses and steady levels
// Notes: bits 31..28 and 5..0 are not held here and read as zero
`timescale 1ns/10ps

module metrology_event_status_flags #(
  parameter longint unsigned PF_CYCLES = evt_flags_pkg::PF_PERIOD_CYCLES
) (
  input wire logic i_clk, // 100 MHz system clock
  input wire logic i_resetn, // async reset, active low
  input wire evt_flags_pkg::zx_events_t i_zx, // datapath event pulses
  input wire evt_flags_pkg::levels_t i_lvl, // datapath levels and checksum
  input wire logic i_first_pulse_out, // first energy pulse pin level
  input wire logic i_second_pulse_out, // second energy pulse pin level
  input wire evt_flags_pkg::reg_req_t i_req, // host register request
  output logic [31:0] o_rdata, // read data, registered
  output logic o_rvalid, // read data valid, pulse
  output logic [15:0] o_checksum_result, // latest checksum, registered
  output logic o_pf_update // power factor refresh strobe
);
  // ****************************************************************
  // event detection
  // ****************************************************************
  localparam int unsigned LW = 3 + 3 + 1 + 16;
  localparam int unsigned PFW = $clog2(PF_CYCLES + 1);

  logic [31:0] status_q, status_d;
  logic [31:0] set_vec, clr_vec;
  logic [LW-1:0] lvl_vec;
  logic lvl_changed;
  logic [1:0] pin_fell;
  logic app_chg, act_chg, isum_chg, config_checksum_changed_flag;
  logic [LW-1:0] prev_lvl_q;
  logic [1:0] last_v_q, last_v_d;
  logic order_err;
  logic [PFW-1:0] pf_cnt_q;
  logic pf_tick;
  logic [4:0] rst_cnt_q;
  logic rst_done_pulse;
  logic hit;

  assign lvl_vec = {i_lvl.app_noload, i_lvl.act_noload, i_lvl.isum_over,
                    i_lvl.crc_value};

  evt_edge_watch #(.W(LW)) u_lvl_watch (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_level(lvl_vec),
    .o_changed(lvl_changed),
    .o_fell()
  );

  evt_edge_watch #(.W(2)) u_pin_watch (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_level({i_second_pulse_out, i_first_pulse_out}),
    .o_changed(),
    .o_fell(pin_fell)
  );

  // per-group change, compared against the previous sample
  assign app_chg = lvl_changed &&
    (prev_lvl_q[LW-1 -: 3] != lvl_vec[LW-1 -: 3]);
  assign act_chg = lvl_changed && (prev_lvl_q[19:17] != lvl_vec[19:17]);
  assign isum_chg = lvl_changed && (prev_lvl_q[16] != lvl_vec[16]);
  assign config_checksum_changed_flag = lvl_changed && (prev_lvl_q[15:0] != lvl_vec[15:0]);

  // phase of each voltage crossing, kept as the last one seen; 3 means none seen yet
  function automatic logic [1:0] phase_of(input logic [2:0] zx);
    phase_of = zx[0] ? 2'h0 : (zx[1] ? 2'h1 : 2'h2);
  endfunction

  assign order_err = (|i_zx.volt_zx) && (last_v_q != 2'h3) &&
    (phase_of(i_zx.volt_zx) != ((last_v_q == 2'h2) ? 2'h0 : last_v_q + 2'h1));
  assign last_v_d = (|i_zx.volt_zx) ? phase_of(i_zx.volt_zx) : last_v_q;

  assign pf_tick = (pf_cnt_q == PFW'(PF_CYCLES - 1));
  assign o_pf_update = pf_tick;

  assign rst_done_pulse =
    (rst_cnt_q == 5'(evt_flags_pkg::RST_DONE_CYCLES - 1));

  always_comb begin
    set_vec = '0;
    set_vec[evt_flags_pkg::BIT_AUXILIARY_CHANNEL_1] = i_zx.aux_zx[1];
    set_vec[evt_flags_pkg::BIT_AUXILIARY_CHANNEL_0] = i_zx.aux_zx[0];
    set_vec[evt_flags_pkg::BIT_IZX_A +: 3] = i_zx.cur_zx;
    set_vec[evt_flags_pkg::BIT_VZX_COMB] = i_zx.comb_zx;
    set_vec[evt_flags_pkg::BIT_VZX_A +: 3] = i_zx.volt_zx;
    set_vec[evt_flags_pkg::BIT_TIMEOUT_A +: 3] = i_zx.zx_timeout;
    set_vec[evt_flags_pkg::BIT_ORDER] = order_err;
    set_vec[evt_flags_pkg::BIT_RST_DONE] = rst_done_pulse;
    set_vec[evt_flags_pkg::BIT_CONFIG_CHECKSUM_CHANGED_FLAG] = config_checksum_changed_flag;
    set_vec[evt_flags_pkg::BIT_APP_NL] = app_chg;
    set_vec[evt_flags_pkg::BIT_ACT_NL] = act_chg;
    set_vec[evt_flags_pkg::BIT_ISUM] = isum_chg;
    set_vec[evt_flags_pkg::BIT_POWER_FACTOR_READY_FLAG] = pf_tick;
    set_vec[evt_flags_pkg::BIT_RMS_ONE] = i_zx.rms_one_upd;
    set_vec[evt_flags_pkg::BIT_PULSE2] = pin_fell[1];
    set_vec[evt_flags_pkg::BIT_PULSE1] = pin_fell[0];
  end

  // ****************************************************************
  // register access
  // ****************************************************************
  assign hit = (i_req.addr == evt_flags_pkg::EVT_STATUS_ADDR);
  assign clr_vec = (i_req.wr && hit) ? i_req.wdata : '0;
  // set wins over a same-cycle clear
  assign status_d = ((status_q & ~clr_vec) | set_vec) &
                    evt_flags_pkg::EVT_IMPL_MASK;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_q <= evt_flags_pkg::EVT_STATUS_RESET;
      prev_lvl_q <= '0;
      last_v_q <= 2'h3;
      pf_cnt_q <= '0;
      rst_cnt_q <= '0;
      o_checksum_result <= 16'h0000;
      o_rdata <= 32'h0000_0000;
      o_rvalid <= 1'b0;
    end else begin
      status_q <= status_d;
      prev_lvl_q <= lvl_vec;
      last_v_q <= last_v_d;
      pf_cnt_q <= pf_tick ? '0 : pf_cnt_q + PFW'(1);
      if (rst_cnt_q != 5'(evt_flags_pkg::RST_DONE_CYCLES)) begin
        rst_cnt_q <= rst_cnt_q + 5'h1;
      end
      o_checksum_result <= i_lvl.crc_value;
      o_rvalid <= i_req.rd;
      o_rdata <= (i_req.rd && hit) ? status_q : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_sticky_hold: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (status_q[evt_flags_pkg::BIT_AUXILIARY_CHANNEL_1] && !clr_vec[evt_flags_pkg::BIT_AUXILIARY_CHANNEL_1])
    |=> status_q[evt_flags_pkg::BIT_AUXILIARY_CHANNEL_1])
    else $error("sticky flag dropped without clear");
  a_aux_set: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_zx.aux_zx[0] |=> status_q[evt_flags_pkg::BIT_AUXILIARY_CHANNEL_0])
    else $error("auxiliary_channel_0 crossing not flagged");
  a_cur_set: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_zx.cur_zx[2] |=> status_q[evt_flags_pkg::BIT_IZX_A + 2])
    else $error("phase c current crossing not flagged");
  a_comb_set: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_zx.comb_zx |=> status_q[evt_flags_pkg::BIT_VZX_COMB])
    else $error("combined crossing not flagged");
  a_volt_set: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_zx.volt_zx[1] |=> status_q[evt_flags_pkg::BIT_VZX_A + 1])
    else $error("phase b voltage crossing not flagged");
  a_timeout_set: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_zx.zx_timeout[0] |=> status_q[evt_flags_pkg::BIT_TIMEOUT_A])
    else $error("timeout not flagged");
  a_order_set: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ((i_zx.volt_zx == 3'b100) && (last_v_q == 2'h2))
    |=> status_q[evt_flags_pkg::BIT_ORDER])
    else $error("repeated phase c crossing not flagged");
  a_crc_copy: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    config_checksum_changed_flag |=> (o_checksum_result == $past(i_lvl.crc_value)))
    else $error("new checksum not readable");
  a_pulse1_fall: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ($fell(i_first_pulse_out) && $past(i_resetn))
    |=> status_q[evt_flags_pkg::BIT_PULSE1])
    else $error("first pulse edge not flagged");
  a_pulse2_fall: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ($fell(i_second_pulse_out) && $past(i_resetn))
    |=> status_q[evt_flags_pkg::BIT_PULSE2])
    else $error("second pulse edge not flagged");
  a_rst_done: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    rst_done_pulse |=> status_q[evt_flags_pkg::BIT_RST_DONE])
    else $error("reset completion not flagged");
  a_clear_works: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (clr_vec[evt_flags_pkg::BIT_RMS_ONE] &&
     !set_vec[evt_flags_pkg::BIT_RMS_ONE])
    |=> !status_q[evt_flags_pkg::BIT_RMS_ONE])
    else $error("write one did not clear");
endmodule // metrology_event_status_flags

// ---- bench/metrology_event_status_flags_tb_top.sv ----
// Purpose: self-checking bench for the sticky event status word
// Assumes: power factor period shortened to 50 cycles for the run
// Notes: bit 9 is masked where the periodic refresh may land
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module metrology_event_status_flags_tb_top;
  localparam logic [15:0] A = evt_flags_pkg::EVT_STATUS_ADDR;
  localparam logic [31:0] M = 32'hFFFF_FDFF;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  evt_flags_pkg::zx_events_t zx = '0;
  evt_flags_pkg::levels_t lvl = '0;
  evt_flags_pkg::reg_req_t req = '0;
  logic [1:0] pin = 2'b00;
  logic [31:0] o_rdata, d;
  logic o_rvalid, o_pf_update;
  logic [15:0] o_checksum_result;
  logic [$bits(zx)-1:0] zr [17];
  logic [$bits(lvl)-1:0] lr [17];
  logic [31:0] er [17];
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  metrology_event_status_flags #(.PF_CYCLES(50)) dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_zx(zx), .i_lvl(lvl),
    .i_first_pulse_out(pin[0]), .i_second_pulse_out(pin[1]), .i_req(req),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_checksum_result(o_checksum_result), .o_pf_update(o_pf_update));

  always #5 i_clk = ~i_clk;

  // ****************************************************************
  // bus tasks and closing
  // ****************************************************************
  task automatic cyc();
    @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    cyc(); req.rd = 1'b1; req.addr = a;
    cyc(); req.rd = 1'b0;
    `CHK("rvalid", 1'b1, o_rvalid)
    v = o_rdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    cyc(); req.wr = 1'b1; req.addr = a; req.wdata = v;
    cyc(); req.wr = 1'b0;
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, far above the ~400 cycles needed
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      results();
    end
  end

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    for (int j = 0; j < 13; j++) begin
      zr[j] = 1 << j; lr[j] = '0;
      er[j] = (j == 0) ? 32'h0000_0100 : 32'h1 << (j + 15);
    end
    lr[13] = 1 << 20; lr[14] = 1 << 17; lr[15] = 1 << 16; lr[16] = 1;
    er[13] = 32'h0000_1000; er[14] = 32'h0000_0800;
    er[15] = 32'h0000_0400; er[16] = 32'h0000_2000;
    for (int j = 13; j < 17; j++) zr[j] = '0;
    repeat (2) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    rd(A, d); `CHK("after_reset", 32'h0000_0000, d)
    repeat (20) cyc();
    rd(A, d); `CHK("reset_done", 32'h0000_4000, d & M)
    // one event per row: set, keep, clear
    for (int j = 0; j < 17; j++) begin
      wr(A, 32'hFFFF_FFFF);
      cyc(); zx = zr[j]; lvl = evt_flags_pkg::levels_t'(lvl ^ lr[j]);
      cyc(); zx = '0; rd(A, d);
      `CHK("set", er[j], d & M)
      wr(A, 32'h0000_0000);
      rd(A, d); `CHK("row_keep", er[j], d & M)
      wr(A, er[j]);
      rd(A, d); `CHK("row_clear", 32'h0000_0000, d & M)
    end
    `CHK("crc_result", lvl.crc_value, o_checksum_result)
    // after A, B, C a second C breaks the order
    cyc(); zx.volt_zx = 3'b100;
    cyc(); zx = '0;
    rd(A, d); `CHK("order", 32'h0020_8000, d & M)
    // set beats clear; unmapped write is ignored
    wr(A, 32'hFFFF_FFFF);
    cyc(); zx.aux_zx = 2'b01; req.wr = 1'b1; req.wdata = 32'h0400_0000;
    cyc(); zx = '0; req.wr = 1'b0;
    wr(A + 16'h0004, 32'hFFFF_FFFF);
    rd(A, d); `CHK("set_wins", 32'h0400_0000, d & M)
    rd(A + 16'h0004, d); `CHK("unmapped", 32'h0000_0000, d)
    // only a pin's falling edge counts
    for (int k = 0; k < 2; k++) begin
      cyc(); pin[k] = 1'b1;
      wr(A, 32'hFFFF_FFFF);
      rd(A, d); `CHK("pin_rise", 32'h0000_0000, d & M)
      cyc(); pin[k] = 1'b0;
      rd(A, d); `CHK("pin_fall", 32'h40 << k, d & M)
    end
    n = 0;
    while (!o_pf_update && n < 200) begin cyc(); n++; end
    n = 0;
    do begin cyc(); n++; end while (!o_pf_update && n < 200);
    `CHK("pf_period", 50, n)
    rd(A, d); `CHK("pf_flag", 32'h0000_0200, d & 32'h0000_0200)
    // mid-run reset with flags and levels held
    i_resetn = 1'b0;
    cyc(); `CHK("rst_rdata", 32'h0000_0000, o_rdata)
    i_resetn = 1'b1;
    rd(A, d); `CHK("reset_again", 32'h0000_0000, d)
    results();
  end
endmodule // metrology_event_status_flags_tb_top
